// File: rtl/sfd_cfg.svh
/*
  constants of the serial fraction divider: register offsets, field positions,
  reset values and digit-time figures.
  assumes: included by bare name from the package and the divider module.
*/
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH

// ----------------------------------------------------------------
// digit times within one word time
// ----------------------------------------------------------------
`define SFD_DT_LAST        5'h14
`define SFD_DT_CMP_END     5'h07
`define SFD_DT_TRK_BEG     5'h08
`define SFD_DT_TRK_END     5'h0d
`define SFD_DT_MAG_END     5'h11
`define SFD_DT_SIGN        5'h12
`define SFD_DT_DECIDE      5'h13

// ----------------------------------------------------------------
// word and field layout
// ----------------------------------------------------------------
`define SFD_MAG_W          17
`define SFD_WORD_W         18
`define SFD_SECT_W         7
`define SFD_TRK_W          6
`define SFD_XT_W           5
`define SFD_OP_DIVIDE      5'h1a
`define SFD_INS_OP_LSB     0
`define SFD_INS_XT_LSB     5
`define SFD_INS_SECT_LSB   10
`define SFD_INS_TRK_LSB    17

// ----------------------------------------------------------------
// register byte addresses (word index times four)
// ----------------------------------------------------------------
`define SFD_ADDR_W         5
`define SFD_OFS_ACC        5'h00
`define SFD_OFS_EXT        5'h04
`define SFD_OFS_INSTR      5'h08
`define SFD_OFS_CTRL       5'h0c
`define SFD_OFS_STATUS     5'h10
`define SFD_CTRL_START     0
`define SFD_CTRL_CLR_OVF   1
`define SFD_RST_WORD       18'h00000
`define SFD_RST_INSTR      32'h00000000

`endif

// File: rtl/sfd_divider.sv
/*
  serial fraction divider: divide sequencer of a drum-memory control computer,
  with its accumulator, extension, operand and pseudo-address registers,
  reached over an avalon-mm slave with waitrequest.
  assumes: drum word, sector number and hold button arrive from outside the
  clock domain; one core_clk cycle is one digit time; the drum runs freely.
*/
// Decided for this implementation: the Avalon-MM register port and the register addresses.
// Notes on behaviour
// - divide starts only when the instruction's operation field holds the divide code.
// - quotient ends in accumulator, remainder in extension register, no rounding.
// - quotient is a fraction; quotient of one or more sets overflow, fills ones.
// - first iterative word sets overflow if dividend is not less than divisor; counts in execution time.
// - divide lasts the search, then two word times plus the programmed execution time.
// - search keeps registers recirculating, compares sector 1-7, copies track 8-13.
// - equality at digit 19 without hold enters setup and clears carry.
// - setup 1-17 loads divisor from drum, dividend into extension, zeros accumulator.
// - setup 1-7 adds execution time to sector number, giving pseudo address.
// - setup 18 writes plus into extension, operand; accumulator sign from sign compare.
// - setup 19 clears quotient flop and first flag, sets carry, enters iteration.
// - first iterative word forces zero into accumulator bit 1, shifts left, keeps sign.
// - add carry and complemented divisor to remainder, write back shifted left.
// - remainder overflow sets quotient flop; at 19 carry takes its complement.
// - every iterative digit 19 sets first flag and samples sector equality.
// - later words shift complement of overflow into accumulator bit 1, keep sign.
// - when carry is zero, add true divisor instead, same left shift.
// - equality with pseudo address at digit 19 enters correction.
// - correction writes complemented quotient flop into bit 1, shifts, restores sign.
// - quotient flop clear: remainder shifted right, zero at its top.
// - quotient flop true: divisor added to remainder, result shifted right.
// - correction 18 copies quotient sign into remainder sign; 19 returns to fetch.
`timescale 1ns/100ps
`include "sfd_cfg.svh"

module sfd_divider
  import sfd_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  input  wire logic [`SFD_ADDR_W-1:0]     avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic [`SFD_WORD_W-1:0]     drum_word,
  input  wire logic [`SFD_SECT_W-1:0]     sector_num,
  input  wire logic                       hold_button,
  output logic      [`SFD_TRK_W-1:0]      track_sel,
  output logic                            busy
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int MW = `SFD_MAG_W;

  sfd_state_t                 state_ff;
  logic [4:0]                 dt_ff;
  logic [`SFD_WORD_W-1:0]     drum_m_ff;
  logic [`SFD_WORD_W-1:0]     drum_ff;
  logic [`SFD_SECT_W-1:0]     sect_m_ff;
  logic [`SFD_SECT_W-1:0]     sect_ff;
  logic                       hold_m_ff;
  logic                       hold_ff;
  logic [`SFD_WORD_W-1:0]     acc_ff;
  logic [`SFD_WORD_W-1:0]     ext_ff;
  logic [`SFD_WORD_W-1:0]     opd_ff;
  logic [`SFD_SECT_W-1:0]     pseudo_ff;
  logic [31:0]                instr_ff;
  logic                       eq_ff;
  logic                       carry_flop;
  logic                       quotient_bit_flop;
  logic                       first_word_flag;
  logic                       overflow_ff;
  logic [`SFD_TRK_W-1:0]      track_ff;
  logic                       ack_ff;
  logic [31:0]                rdata_ff;
  logic                       start_req;
  logic                       bus_req;
  logic [MW:0]                nxt_sum;
  logic [MW:0]                nxt_corr;
  logic                       dt_is_last;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic dt_in(input logic [4:0] dt, input logic [4:0] lo, input logic [4:0] hi);
    dt_in = (dt >= lo) && (dt <= hi);
  endfunction

  function automatic logic [31:0] word_to_bus(input logic [`SFD_WORD_W-1:0] w);
    word_to_bus = {14'h0000, w};
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      drum_m_ff <= `SFD_RST_WORD;
      drum_ff   <= `SFD_RST_WORD;
      sect_m_ff <= '0;
      sect_ff   <= '0;
      hold_m_ff <= 1'b0;
      hold_ff   <= 1'b0;
    end else begin
      drum_m_ff <= drum_word;
      drum_ff   <= drum_m_ff;
      sect_m_ff <= sector_num;
      sect_ff   <= sect_m_ff;
      hold_m_ff <= hold_button;
      hold_ff   <= hold_m_ff;
    end
  end

  // ----------------------------------------------------------------
  // digit-time counter, 1 to 20 within each word time
  // ----------------------------------------------------------------
  assign dt_is_last = (dt_ff == `SFD_DT_LAST);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dt_ff <= 5'h01;
    end else if (dt_is_last) begin
      dt_ff <= 5'h01;
    end else begin
      dt_ff <= dt_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, answer at the second edge
  // ----------------------------------------------------------------
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign start_req       = avs_write & ack_ff & (avs_address == `SFD_OFS_CTRL)
                           & avs_writedata[`SFD_CTRL_START];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 32'h00000000;
    end else if (avs_read & ~ack_ff) begin
      unique case (avs_address)
        `SFD_OFS_ACC:    rdata_ff <= word_to_bus(acc_ff);
        `SFD_OFS_EXT:    rdata_ff <= word_to_bus(ext_ff);
        `SFD_OFS_INSTR:  rdata_ff <= instr_ff;
        `SFD_OFS_STATUS: rdata_ff <= {19'h00000, track_ff, state_ff, overflow_ff, busy};
        default:         rdata_ff <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      instr_ff <= `SFD_RST_INSTR;
    end else if (avs_write & ack_ff & (avs_address == `SFD_OFS_INSTR) & ~busy) begin
      instr_ff <= avs_writedata;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign busy = (state_ff != SFD_FETCH);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= SFD_FETCH;
    end else begin
      unique case (state_ff)
        SFD_FETCH: begin
          if (start_req && instr_ff[`SFD_INS_OP_LSB +: 5] == `SFD_OP_DIVIDE) begin
            state_ff <= SFD_SEARCH;
          end
        end
        SFD_SEARCH: begin
          if (dt_ff == `SFD_DT_DECIDE && eq_ff && !hold_ff) begin
            state_ff <= SFD_SETUP;
          end
        end
        SFD_SETUP: begin
          if (dt_ff == `SFD_DT_DECIDE) begin
            state_ff <= SFD_ITER;
          end
        end
        SFD_ITER: begin
          if (dt_ff == `SFD_DT_DECIDE && eq_ff) begin
            state_ff <= SFD_CORR;
          end
        end
        SFD_CORR: begin
          if (dt_ff == `SFD_DT_DECIDE) begin
            state_ff <= SFD_FETCH;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sector equality: search compares operand sector, later the pseudo address
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      eq_ff <= 1'b0;
    end else if (dt_ff == `SFD_DT_CMP_END) begin
      eq_ff <= (sect_ff == pseudo_ff);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pseudo_ff <= '0;
    end else if (state_ff == SFD_FETCH && start_req) begin
      pseudo_ff <= instr_ff[`SFD_INS_SECT_LSB +: `SFD_SECT_W];
    end else if (state_ff == SFD_SETUP && dt_ff == `SFD_DT_CMP_END) begin
      pseudo_ff <= sect_ff + `SFD_SECT_W'(instr_ff[`SFD_INS_XT_LSB +: `SFD_XT_W]);
    end
  end

  // operand track copied to the track-select flops in digit times 8 to 13
  always_ff @(posedge core_clk) begin
    if (srst) begin
      track_ff <= '0;
    end else if (state_ff == SFD_SEARCH && dt_in(dt_ff, `SFD_DT_TRK_BEG, `SFD_DT_TRK_END)) begin
      track_ff <= instr_ff[`SFD_INS_TRK_LSB +: `SFD_TRK_W];
    end
  end

  assign track_sel = track_ff;

  // ----------------------------------------------------------------
  // remainder step and correction arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sum  = ext_ff
             + (carry_flop ? ~{1'b0, opd_ff[MW-1:0]} : {1'b0, opd_ff[MW-1:0]})
             + {{MW{1'b0}}, carry_flop};
    nxt_corr = ext_ff + {opd_ff[MW-1:0], 1'b0};
  end

  // ----------------------------------------------------------------
  // accumulator: quotient
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_ff <= `SFD_RST_WORD;
    end else if (state_ff == SFD_FETCH) begin
      if (avs_write && ack_ff && avs_address == `SFD_OFS_ACC) begin
        acc_ff <= avs_writedata[`SFD_WORD_W-1:0];
      end
    end else if (state_ff == SFD_SETUP) begin
      if (dt_ff == `SFD_DT_MAG_END) begin
        acc_ff[MW-1:0] <= '0;
      end else if (dt_ff == `SFD_DT_SIGN) begin
        acc_ff[MW] <= acc_ff[MW] ^ drum_ff[MW];
      end
    end else if (state_ff == SFD_ITER && dt_ff == `SFD_DT_MAG_END) begin
      if (!first_word_flag) begin
        acc_ff[MW-1:0] <= {acc_ff[MW-2:0], 1'b0};
      end else begin
        acc_ff[MW-1:0] <= {acc_ff[MW-2:0], ~quotient_bit_flop};
      end
    end else if (state_ff == SFD_CORR) begin
      if (dt_ff == `SFD_DT_MAG_END) begin
        acc_ff[MW-1:0] <= {acc_ff[MW-2:0], ~quotient_bit_flop};
      end else if (dt_ff == `SFD_DT_SIGN && overflow_ff) begin
        acc_ff <= {`SFD_WORD_W{1'b1}};
      end
    end
  end

  // ----------------------------------------------------------------
  // extension register: partial remainder
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_ff <= `SFD_RST_WORD;
    end else if (state_ff == SFD_FETCH) begin
      if (avs_write && ack_ff && avs_address == `SFD_OFS_EXT) begin
        ext_ff <= avs_writedata[`SFD_WORD_W-1:0];
      end
    end else if (state_ff == SFD_SETUP) begin
      if (dt_ff == `SFD_DT_MAG_END) begin
        ext_ff[MW-1:0] <= acc_ff[MW-1:0];
      end else if (dt_ff == `SFD_DT_SIGN) begin
        ext_ff[MW] <= 1'b0;
      end
    end else if (state_ff == SFD_ITER && dt_ff == `SFD_DT_MAG_END) begin
      ext_ff <= {nxt_sum[MW-1:0], 1'b0};
    end else if (state_ff == SFD_CORR) begin
      if (dt_ff == `SFD_DT_MAG_END) begin
        if (!quotient_bit_flop) begin
          ext_ff <= {1'b0, ext_ff[MW:1]};
        end else begin
          ext_ff <= {1'b0, nxt_corr[MW:1]};
        end
      end else if (dt_ff == `SFD_DT_SIGN) begin
        if (overflow_ff) begin
          ext_ff <= {`SFD_WORD_W{1'b1}};
        end else begin
          ext_ff[MW] <= acc_ff[MW];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // operand register: divisor
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      opd_ff <= `SFD_RST_WORD;
    end else if (state_ff == SFD_SETUP) begin
      if (dt_ff == `SFD_DT_MAG_END) begin
        opd_ff[MW-1:0] <= drum_ff[MW-1:0];
      end else if (dt_ff == `SFD_DT_SIGN) begin
        opd_ff[MW] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control flops: carry, quotient digit, first word
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      carry_flop <= 1'b0;
    end else if (state_ff == SFD_SEARCH && dt_ff == `SFD_DT_DECIDE && eq_ff && !hold_ff) begin
      carry_flop <= 1'b0;
    end else if (state_ff == SFD_SETUP && dt_ff == `SFD_DT_DECIDE) begin
      carry_flop <= 1'b1;
    end else if (state_ff == SFD_ITER && dt_ff == `SFD_DT_DECIDE) begin
      carry_flop <= ~quotient_bit_flop;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      quotient_bit_flop <= 1'b0;
    end else if (state_ff == SFD_SETUP && dt_ff == `SFD_DT_DECIDE) begin
      quotient_bit_flop <= 1'b0;
    end else if (state_ff == SFD_ITER && dt_ff == `SFD_DT_MAG_END) begin
      quotient_bit_flop <= nxt_sum[MW];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      first_word_flag <= 1'b0;
    end else if (state_ff == SFD_SETUP && dt_ff == `SFD_DT_DECIDE) begin
      first_word_flag <= 1'b0;
    end else if (state_ff == SFD_ITER && dt_ff == `SFD_DT_DECIDE) begin
      first_word_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // overflow: set by hardware, cleared by software; set wins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_ff <= 1'b0;
    end else if (state_ff == SFD_ITER && dt_ff == `SFD_DT_MAG_END && !first_word_flag
                 && !nxt_sum[MW]) begin
      overflow_ff <= 1'b1;
    end else if (avs_write && ack_ff && avs_address == `SFD_OFS_CTRL
                 && avs_writedata[`SFD_CTRL_CLR_OVF]) begin
      overflow_ff <= 1'b0;
    end
  end

endmodule // sfd_divider

// File: rtl/sfd_pkg.sv
/*
  types of the serial fraction divider.
  assumes: sfd_cfg.svh sits beside this file on the include path.
*/
`include "sfd_cfg.svh"

package sfd_pkg;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SFD_FETCH  = 5'h01,
    SFD_SEARCH = 5'h02,
    SFD_SETUP  = 5'h04,
    SFD_ITER   = 5'h08,
    SFD_CORR   = 5'h10
  } sfd_state_t;

  typedef logic [`SFD_MAG_W-1:0] sfd_mag_t;

endpackage

// File: testbench/sfd_divider_sva.sv
/* checker of divider ports: bus handshake, start cause, busy span, track hold.
   assumes: bound to sfd_divider; one clock; srst synchronous, active high. */
`timescale 1ns/100ps
module sfd_divider_sva (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [5:0]  track_sel,
  input wire logic        busy
);
  logic [11:0] busy_cnt_ff;
  logic [11:0] nxt_busy_cnt;
  // ----------------
  // busy span counter
  // ----------------
  assign nxt_busy_cnt = busy ? busy_cnt_ff + 12'h001 : 12'h000;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_cnt_ff <= 12'h000;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_req_rise;
    $rose(avs_read) || $rose(avs_write);
  endsequence
  a_wait_once: assert property (s_req_wait |=> !avs_waitrequest) else $error("wait longer than one cycle");
  a_wait_first: assert property (s_req_rise |-> avs_waitrequest) else $error("new request not stalled");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
  a_rdata_stable: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  a_upper_zero: assert property (avs_readdata[31:18] == 14'h0000) else $error("upper read bits set");
  a_start_cause: assert property ($rose(busy) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("busy rose without a write");
  a_track_idle: assert property ($changed(track_sel) |-> $past(busy))
    else $error("track moved while idle");
  a_busy_min: assert property ($fell(busy) |-> busy_cnt_ff >= 12'h03c)
    else $error("divide too short");
  a_busy_max: assert property (busy |-> busy_cnt_ff < 12'he74)
    else $error("divide too long");
endmodule // sfd_divider_sva

bind sfd_divider sfd_divider_sva u_sva (.core_clk(core_clk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .track_sel(track_sel), .busy(busy));

// File: testbench/sfd_drum_model.sv
/* drum read channel and sector track model: free sector count, one word per track.
   assumes: same core_clk and srst as the divider; a word time is 20 cycles. */
`timescale 1ns/100ps
module sfd_drum_model (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [5:0]  track_sel,
  input  wire logic [5:0]  op_track,
  input  wire logic [17:0] op_word,
  output logic      [17:0] drum_word,
  output logic      [6:0]  sector_num
);
  logic [4:0] digit_ff;
  logic [6:0] sector_ff;
  // sector number advances once per word time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      digit_ff  <= 5'h01;
      sector_ff <= 7'h00;
    end else if (digit_ff == 5'h14) begin
      digit_ff  <= 5'h01;
      sector_ff <= sector_ff + 7'h01;
    end else begin
      digit_ff <= digit_ff + 5'h01;
    end
  end
  assign sector_num = sector_ff;
  // other tracks read back the inverse so a wrong track shows
  assign drum_word  = (track_sel == op_track) ? op_word : ~op_word;
endmodule // sfd_drum_model

// File: testbench/test_sfd_divider.sv
/* testbench of the divider: avalon-mm master tasks, drum model, expected
   quotient and remainder from long division.
   assumes: package, divider, drum model and checker compiled before it. */
`timescale 1ns/100ps
`include "sfd_cfg.svh"
module test_sfd_divider
  import sfd_pkg::*;
;
  logic        core_clk;
  logic        srst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [17:0] drum_word;
  logic [17:0] op_word;
  logic [6:0]  sector_num;
  logic        hold_button;
  logic [5:0]  track_sel;
  logic [5:0]  op_track;
  logic        busy;
  logic [31:0] rdat;
  logic [31:0] r;
  logic [16:0] m;
  logic [4:0]  bad_op [3];
  integer      seed;
  int          bad_count;
  int          num_checks;
  int          cyc;

  always #10 core_clk = ~core_clk;

  sfd_divider u_dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drum_word(drum_word), .sector_num(sector_num),
    .hold_button(hold_button), .track_sel(track_sel), .busy(busy));
  sfd_drum_model u_drum (.core_clk(core_clk), .srst(srst), .track_sel(track_sel), .op_track(op_track),
    .op_word(op_word), .drum_word(drum_word), .sector_num(sector_num));

  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
    logic w;
    int   n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr_en;
    avs_write     <= wr_en;
    do begin
      @(posedge core_clk);
      w    = avs_waitrequest;
      rdat = avs_readdata;
      n++;
    end while (w !== 1'b0 && n < 20);
    chk({31'h0, w}, 32'h0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // expected {overflow, quotient word, remainder word}
  function automatic logic [36:0] exp_div(input logic [17:0] dvd, input logic [17:0] dvs, input logic [4:0] xt);
    logic [63:0] num;
    logic [63:0] qv;
    logic [63:0] rv;
    logic        sg;
    sg  = dvd[17] ^ dvs[17];
    num = {47'h0, dvd[16:0]} << (xt - 5'h01);
    qv  = num / {47'h0, dvs[16:0]};
    rv  = num - qv * {47'h0, dvs[16:0]};
    if (dvd[16:0] >= dvs[16:0]) begin
      return {1'b1, 36'hfffffffff};
    end
    return {1'b0, sg, qv[16:0], sg, rv[16:0]};
  endfunction

  task automatic run_div(input logic [17:0] dvd, input logic [17:0] dvs, input logic [4:0] xt, input logic hold);
    logic [36:0] e;
    logic [6:0]  sec;
    int          n;
    r   = $random(seed);
    sec = hold ? sector_num + 7'h03 : r[12:6];
    e   = exp_div(dvd, dvs, xt);
    op_word     <= dvs;
    op_track    <= r[5:0];
    hold_button <= hold;
    wr(`SFD_OFS_CTRL, 32'h2);
    wr(`SFD_OFS_ACC, {14'h0, dvd});
    wr(`SFD_OFS_INSTR, {9'h0, r[5:0], sec, xt, `SFD_OP_DIVIDE});
    wr(`SFD_OFS_CTRL, 32'h1);
    wr(`SFD_OFS_ACC, 32'h2aaaa);
    if (hold) begin
      repeat (400) @(posedge core_clk);
      rd(`SFD_OFS_STATUS);
      chk({25'h0, rdat[6:0]}, 32'h9);
      hold_button <= 1'b0;
    end
    n = 0;
    do begin
      rd(`SFD_OFS_STATUS);
      n++;
    end while (rdat[0] !== 1'b0 && n < 1500);
    chk({31'h0, rdat[0]}, 32'h0);
    chk({31'h0, rdat[1]}, {31'h0, e[36]});
    rd(`SFD_OFS_ACC);
    chk(rdat, {14'h0, e[35:18]});
    rd(`SFD_OFS_EXT);
    chk(rdat, {14'h0, e[17:0]});
    chk({26'h0, track_sel}, {26'h0, r[5:0]});
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    seed          = 32'h8e14;
    core_clk      = 1'b0;
    srst          = 1'b1;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    hold_button   = 1'b0;
    op_word       = 18'h00000;
    op_track      = 6'h00;
    bad_count     = 0;
    num_checks    = 0;
    cyc           = 0;
    bad_op        = '{5'h10, 5'h05, 5'h1b};
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(`SFD_OFS_ACC);
    chk(rdat, {14'h0, `SFD_RST_WORD});
    rd(5'h14);
    chk(rdat, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`SFD_OFS_INSTR, {22'h0, 5'h06, bad_op[i]});
      wr(`SFD_OFS_CTRL, 32'h1);
      rd(`SFD_OFS_STATUS);
      chk({31'h0, rdat[0]}, 32'h0);
    end
    run_div(18'h00012, 18'h0001b, 5'h06, 1'b0);
    run_div(18'h20012, 18'h0001b, 5'h06, 1'b0);
    run_div(18'h20012, 18'h2001b, 5'h06, 1'b0);
    run_div(18'h1fffe, 18'h1ffff, 5'h12, 1'b0);
    run_div(18'h00001, 18'h10000, 5'h02, 1'b0);
    run_div(18'h00000, 18'h00005, 5'h05, 1'b0);
    run_div(18'h00100, 18'h00010, 5'h04, 1'b0);
    run_div(18'h0abcd, 18'h1abce, 5'h09, 1'b1);
    repeat (7) begin
      r = $random(seed);
      m = r[16:0] | 17'h00001;
      r = $random(seed);
      run_div({r[17], r[16:0] % m}, {r[18], m}, 5'h02 + {1'b0, r[22:19]}, 1'b0);
    end
    wrap_up();
  end
endmodule // test_sfd_divider
